//--- core/hyd_lift_lower.sv
// pump armature PWM and lowering valve request, with load-hold valve sequencing
// assumes switches and throttle are synchronous to clk_sys; throttle is 0..32767
`timescale 1ns/10ps
// What this block does
// - lift-only mode: lift switch gives maximum pump
// - otherwise pump request follows the throttle
// - changing either switch-only option latches fault 49
// - lower-only mode: lower switch opens valve fully
// - otherwise valve opening follows the throttle
// - pump PWM never exceeds programmed maximum, or the 0x0ccc floor if that is higher
// - rising pump request ramps at accel rate
// - falling pump request ramps at decel rate
// - rising valve current ramps at lower accel
// - falling valve current ramps at lower decel
// - load-hold enable routes valve to driver four
// - hold valve stays open for programmed delay
// - delay starts when both switches open, pump zero and valve closed
// - hold valve is binary, closes abruptly
// - no throttle: switches ramp to full scale
module hyd_lift_lower
	import hyd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic lift_sw,
	input wire logic lower_sw,
	input wire logic [14:0] hyd_throttle,
	input wire logic [7:0] option_word_four,
	input wire logic load_hold_enable,
	input wire logic [14:0] pump_max_pwm,
	input wire logic [10:0] pump_accel_ms,
	input wire logic [10:0] pump_decel_ms,
	input wire logic [10:0] lower_accel_ms,
	input wire logic [10:0] lower_decel_ms,
	input wire logic [8:0] load_hold_delay,
	output logic [14:0] pump_pwm,
	output logic [14:0] lower_valve_req,
	output logic driver4_out,
	output logic param_fault,
	output logic [7:0] fault_code
);
	typedef enum logic [1:0] {HOLD_SHUT, HOLD_ACTIVE, HOLD_DELAY} hold_e;

	logic [14:0] pump_tgt;
	logic [14:0] lower_tgt;
	logic [14:0] pwm_cap;
	logic [14:0] tgt [RAMP_N];
	logic [10:0] up_ms [RAMP_N];
	logic [10:0] dn_ms [RAMP_N];
	logic [14:0] lvl [RAMP_N];
	logic [14:0] pump_scaled;
	logic [29:0] pump_prod;
	logic [1:0] opt_r;
	logic opt_seen_r;
	logic [31:0] hold_cnt_r;
	logic [31:0] hold_len;
	logic [8:0] delay_c;
	logic active;
	logic lift_only;
	logic lower_only;
	logic [1:0] opt_now;
	logic [14:0] pump_lim;
	logic hold_last;
	hold_e hold_r;

	// only the two switch-only bits take part in the change check
	assign lift_only = option_word_four[LIFT_ONLY_BIT];
	assign lower_only = option_word_four[LOWER_ONLY_BIT];
	assign opt_now = {lower_only, lift_only};

	// maxima below the floor are raised to it rather than refused
	always_comb begin
		pwm_cap = pump_max_pwm;
		if (pump_max_pwm < PWM_MAX_LO) begin
			pwm_cap = PWM_MAX_LO;
		end
	end

	// switch-only forces full scale; the ramp then applies the accel time
	always_comb begin
		pump_tgt = 15'h0000;
		if (lift_sw) begin
			if (lift_only) begin
				pump_tgt = REQ_FULL;
			end else begin
				pump_tgt = hyd_throttle;
			end
		end
	end

	always_comb begin
		lower_tgt = 15'h0000;
		if (lower_sw) begin
			if (lower_only) begin
				lower_tgt = REQ_FULL;
			end else begin
				lower_tgt = hyd_throttle;
			end
		end
	end

	assign tgt[RAMP_PUMP] = pump_tgt;
	assign up_ms[RAMP_PUMP] = pump_accel_ms;
	assign dn_ms[RAMP_PUMP] = pump_decel_ms;
	assign tgt[RAMP_LOWER] = lower_tgt;
	assign up_ms[RAMP_LOWER] = lower_accel_ms;
	assign dn_ms[RAMP_LOWER] = lower_decel_ms;

	for (genvar i = 0; i < RAMP_N; i++) begin : g_ramp
		hyd_ramp u_ramp (
			.clk_sys(clk_sys),
			.sys_rst(sys_rst),
			.target(tgt[i]),
			.up_ms(up_ms[i]),
			.down_ms(dn_ms[i]),
			.level(lvl[i])
		);
	end

	// ramped request is scaled into 0..max so full request gives one count below max PWM
	assign pump_prod = lvl[RAMP_PUMP] * pwm_cap;
	assign pump_scaled = pump_prod[29:15];

	// guard against rounding pushing the duty past the cap
	always_comb begin
		pump_lim = pump_scaled;
		if (pump_scaled > pwm_cap) begin
			pump_lim = pwm_cap;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pump_pwm <= 15'h0000;
			lower_valve_req <= 15'h0000;
		end else begin
			pump_pwm <= pump_lim;
			lower_valve_req <= lvl[RAMP_LOWER];
		end
	end

	// options sampled every cycle after reset; any change of the two switch-only bits latches the fault until sys_rst
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			opt_seen_r <= 1'b0;
			opt_r <= 2'b00;
		end else begin
			opt_seen_r <= 1'b1;
			opt_r <= opt_now;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			param_fault <= 1'b0;
			fault_code <= 8'h00;
		end else if (opt_seen_r && (opt_r != opt_now)) begin
			param_fault <= 1'b1;
			fault_code <= FAULT_PARAM_CHANGE;
		end
	end

	// action lasts while a switch is closed or pump / valve still running
	assign active = lift_sw || lower_sw || (lvl[RAMP_PUMP] != 15'h0000) ||
		(lvl[RAMP_LOWER] != 15'h0000);
	always_comb begin
		delay_c = load_hold_delay;
		if (load_hold_delay > HOLD_MAX) begin
			delay_c = HOLD_MAX;
		end
	end

	assign hold_len = {23'h0, delay_c} * 32'(HOLD_CYC_PER_CNT);
	// a delay shortened to zero mid-hold must still end the hold
	assign hold_last = (hold_len == 32'h0) || (hold_cnt_r >= hold_len - 32'h1);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hold_r <= HOLD_SHUT;
			hold_cnt_r <= 32'h0000_0000;
		end else begin
			case (hold_r)
				HOLD_SHUT: begin
					hold_cnt_r <= 32'h0000_0000;
					if (active) begin
						hold_r <= HOLD_ACTIVE;
					end
				end
				HOLD_ACTIVE: begin
					hold_cnt_r <= 32'h0000_0000;
					if (!active) begin
						hold_r <= (hold_len == 32'h0) ? HOLD_SHUT : HOLD_DELAY;
					end
				end
				HOLD_DELAY: begin
					if (active) begin
						hold_r <= HOLD_ACTIVE;
					end else if (hold_last) begin
						hold_r <= HOLD_SHUT;
					end else begin
						hold_cnt_r <= hold_cnt_r + 32'h1;
					end
				end
				default: begin
					hold_r <= HOLD_SHUT;
				end
			endcase
		end
	end

	// binary output, no ramp; unused for load holding when disabled
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			driver4_out <= 1'b0;
		end else begin
			driver4_out <= load_hold_enable && (active || hold_r == HOLD_ACTIVE ||
				(hold_r == HOLD_DELAY && !hold_last));
		end
	end
endmodule // hyd_lift_lower

//--- core/hyd_pkg.sv
// constants for the hydraulic pump / lowering valve control block
// assumes a 100 MHz system clock; requests are 15-bit unsigned (0..32767)
package hyd_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int REQ_W = 15;
	localparam logic [14:0] REQ_FULL = 15'h7fff;
	localparam logic [14:0] PWM_MAX_LO = 15'h0ccc;
	localparam logic [14:0] PWM_MAX_RST = 15'h7fff;
	localparam int RATE_MS_PER_CNT = 1;
	localparam int RATE_CYC_PER_MS = CLK_HZ / 1000 * RATE_MS_PER_CNT;
	localparam logic [10:0] RATE_MIN = 11'h064;
	localparam logic [10:0] RATE_MAX = 11'h7d0;
	localparam logic [10:0] RATE_RST = 11'h3e8;
	localparam int HOLD_MS_PER_CNT = 8;
	localparam int HOLD_CYC_PER_CNT = CLK_HZ / 1000 * HOLD_MS_PER_CNT;
	localparam logic [8:0] HOLD_MAX = 9'h100;
	localparam int LIFT_ONLY_BIT = 4;
	localparam int LOWER_ONLY_BIT = 5;
	localparam logic [7:0] FAULT_PARAM_CHANGE = 8'h31;
	localparam int RAMP_N = 2;
	localparam int RAMP_PUMP = 0;
	localparam int RAMP_LOWER = 1;
	localparam logic [31:0] RAMP_ACC_FULL = 32'h7fff_0000;
endpackage

//--- core/hyd_ramp.sv
// one linear ramp: the output slews toward the target so full scale takes rate_ms
// assumes rate inputs stay within 100..2000 counts of 1 ms
`timescale 1ns/10ps
module hyd_ramp
	import hyd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [14:0] target,
	input wire logic [10:0] up_ms,
	input wire logic [10:0] down_ms,
	output logic [14:0] level
);
	logic [10:0] up_c;
	logic [10:0] dn_c;
	logic [31:0] acc_r;
	logic [31:0] step_up;
	logic [31:0] step_dn;
	logic [31:0] tgt_acc;
	logic [16:0] ms_cnt_r;
	logic tick;

	assign up_c = (up_ms < RATE_MIN) ? RATE_MIN : ((up_ms > RATE_MAX) ? RATE_MAX : up_ms);
	assign dn_c = (down_ms < RATE_MIN) ? RATE_MIN : ((down_ms > RATE_MAX) ? RATE_MAX : down_ms);
	// full scale in 16.16 fixed point, spread over the programmed millisecond count
	assign step_up = RAMP_ACC_FULL / {21'h0, up_c};
	assign step_dn = RAMP_ACC_FULL / {21'h0, dn_c};
	assign tgt_acc = {1'b0, target, 16'h0000};
	assign tick = (ms_cnt_r == 17'(RATE_CYC_PER_MS - 1));

	always_ff @(posedge clk_sys) begin
		if (sys_rst || tick) begin
			ms_cnt_r <= 17'h00000;
		end else begin
			ms_cnt_r <= ms_cnt_r + 17'h00001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			acc_r <= 32'h0000_0000;
		end else if (tick) begin
			if (acc_r < tgt_acc) begin
				acc_r <= (tgt_acc - acc_r > step_up) ? acc_r + step_up : tgt_acc;
			end else if (acc_r > tgt_acc) begin
				acc_r <= (acc_r - tgt_acc > step_dn) ? acc_r - step_dn : tgt_acc;
			end
		end
	end

	assign level = acc_r[30:16];
endmodule // hyd_ramp

//--- sim/hyd_chk_sva.sv
// checker: fault latch, load-hold valve and pump/valve request limits
// assumes binding to hyd_lift_lower, one clock, synchronous reset
`timescale 1ns/10ps
module hyd_chk
	import hyd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic lift_sw,
	input wire logic lower_sw,
	input wire logic [7:0] option_word_four,
	input wire logic load_hold_enable,
	input wire logic [14:0] pump_max_pwm,
	input wire logic [14:0] pump_pwm,
	input wire logic [14:0] lower_valve_req,
	input wire logic driver4_out,
	input wire logic param_fault,
	input wire logic [7:0] fault_code
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_fault_code_match: assert property (fault_code == (param_fault ? 8'h31 : 8'h00))
		else $error("fault code does not match fault flag");
	a_fault_stays_set: assert property (param_fault |=> param_fault)
		else $error("parameter fault cleared without reset");
	a_fault_on_change: assert property (!$past(sys_rst) &&
		$past(option_word_four[5:4]) != option_word_four[5:4] |-> ##[1:2] param_fault)
		else $error("option change did not raise fault");
	a_hold_off_disabled: assert property (!$past(load_hold_enable) && !load_hold_enable
		|-> !driver4_out) else $error("hold valve driven while disabled");
	a_hold_open_action: assert property ((lift_sw || lower_sw) && load_hold_enable ##1
		(lift_sw || lower_sw) && load_hold_enable |-> driver4_out)
		else $error("hold valve shut during action");
	a_hold_close_idle: assert property ($fell(driver4_out) && $past(load_hold_enable)
		|-> !$past(lift_sw) && !$past(lower_sw)) else $error("hold valve shut with switch closed");
	a_pwm_cap: assert property ($stable(pump_max_pwm) && pump_max_pwm >= PWM_MAX_LO
		|-> pump_pwm <= pump_max_pwm) else $error("pump duty above maximum");
	a_pump_step_small: assert property ($stable(pump_max_pwm) &&
		$past(pump_max_pwm, 2) == pump_max_pwm
		|-> {1'b0, pump_pwm} <= {1'b0, $past(pump_pwm)} + 16'h014a)
		else $error("pump request jumped faster than ramp");
	a_valve_idle: assert property (!lower_sw [*3] |-> lower_valve_req <= $past(lower_valve_req))
		else $error("valve request rose with lower switch open");
endmodule // hyd_chk
bind hyd_lift_lower hyd_chk u_chk(.*);

//--- sim/hyd_operator.sv
// operator model: lift and lower switches and the hydraulic throttle
// assumes requests from the bench, applied at the rising clock edge
`timescale 1ns/10ps
module hyd_operator (
	input wire logic clk_sys,
	input wire logic want_lift,
	input wire logic want_lower,
	input wire logic [14:0] want_level,
	output logic lift_sw,
	output logic lower_sw,
	output logic [14:0] hyd_throttle
);
	always_ff @(posedge clk_sys) begin
		lift_sw <= want_lift;
		lower_sw <= want_lower;
		hyd_throttle <= (want_lift || want_lower) ? want_level : 15'h0000;
	end
endmodule // hyd_operator

//--- sim/tb_top.sv
// testbench: reset values, load-hold valve sequencing, parameter change fault, one ramp step
// assumes hyd_lift_lower, hyd_operator and the bound checker
`timescale 1ns/10ps
module tb_top;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic want_lift = 1'b0;
	logic want_lower = 1'b0;
	logic [14:0] want_level = 15'h4000;
	logic [7:0] opts = 8'h00;
	logic hold_en = 1'b0;
	logic [8:0] hold_dly = 9'h000;
	logic lift_sw, lower_sw, driver4_out, param_fault;
	logic [14:0] hyd_throttle, pump_pwm, lower_valve_req;
	logic [7:0] fault_code;
	int fails = 0;
	int compares = 0;
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	hyd_operator OP(.clk_sys, .want_lift, .want_lower, .want_level, .lift_sw, .lower_sw,
		.hyd_throttle);
	hyd_lift_lower DUT(.clk_sys, .sys_rst, .lift_sw, .lower_sw, .hyd_throttle,
		.option_word_four(opts), .load_hold_enable(hold_en), .pump_max_pwm(15'h6000),
		.pump_accel_ms(11'h064), .pump_decel_ms(11'h064), .lower_accel_ms(11'h0c8),
		.lower_decel_ms(11'h7d0), .load_hold_delay(hold_dly), .pump_pwm, .lower_valve_req,
		.driver4_out, .param_fault, .fault_code);
	task automatic chk(input string nm, input logic [14:0] exp, input logic [14:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic test_done();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		wait_clk(3);
		sys_rst <= 1'b0;
		wait_clk(2);
		chk("pump_pwm", 15'h0000, pump_pwm);
		chk("lower_valve_req", 15'h0000, lower_valve_req);
		chk("driver4_out", 15'h0000, driver4_out);
		chk("param_fault", 15'h0000, param_fault);
		chk("fault_code", 15'h0000, fault_code);
		hold_en <= 1'b1;
		want_lift <= 1'b1;
		wait_clk(4);
		chk("driver4_out", 15'h0001, driver4_out);
		want_lift <= 1'b0;
		wait_clk(6);
		chk("driver4_out", 15'h0000, driver4_out);
		hold_en <= 1'b0;
		want_lower <= 1'b1;
		wait_clk(4);
		chk("driver4_out", 15'h0000, driver4_out);
		want_lower <= 1'b0;
		opts <= 8'h80;
		wait_clk(4);
		chk("param_fault", 15'h0000, param_fault);
		opts <= 8'h90;
		wait_clk(4);
		chk("param_fault", 15'h0001, param_fault);
		chk("fault_code", 15'h0031, fault_code);
		opts <= 8'h80;
		wait_clk(4);
		chk("param_fault", 15'h0001, param_fault);
		sys_rst <= 1'b1;
		wait_clk(3);
		sys_rst <= 1'b0;
		wait_clk(2);
		chk("param_fault", 15'h0000, param_fault);
		opts <= 8'ha0;
		wait_clk(4);
		chk("param_fault", 15'h0001, param_fault);
		// the millisecond tick lands 100000 cycles after the last reset release
		hold_en <= 1'b1;
		want_lift <= 1'b1;
		want_lower <= 1'b1;
		want_level <= 15'h0080;
		wait_clk(4);
		chk("driver4_out", 15'h0001, driver4_out);
		wait_clk(99980);
		chk("pump_pwm", 15'h0000, pump_pwm);
		chk("lower_valve_req", 15'h0000, lower_valve_req);
		wait_clk(20);
		// throttle 128 is under one 100 ms step; scaled by 0x6000 of 0x8000 gives 96
		chk("pump_pwm", 15'h0060, pump_pwm);
		// lower-only: one 1 ms step of a 200 ms full-scale ramp, 32767/200
		chk("lower_valve_req", 15'h00a3, lower_valve_req);
		chk("driver4_out", 15'h0001, driver4_out);
		test_done();
	end
	initial begin
		wait_clk(100200);
		fails++;
		test_done();
	end
endmodule // tb_top
